// *** sample_regs_map.svh ***
`ifndef SAMPLE_REGS_MAP_SVH
`define SAMPLE_REGS_MAP_SVH

// Byte addresses of the sample windows
`define OFS_SAMPLE5_NANOSECONDS 12'h584
`define OFS_SAMPLE5_SECONDS     12'h588
`define OFS_SAMPLE5_PHASE       12'h58c
`define OFS_SAMPLE6_NANOSECONDS 12'h590
`define OFS_SAMPLE6_SECONDS     12'h594
`define OFS_SAMPLE6_PHASE       12'h598
// Local capture control word
`define OFS_SAMPLE_CONTROL      12'h5f0

// Field positions
`define POS_EDGE                30
`define POS_NS_HI               29
`define POS_PHASE_HI            2
`define POS_CTRL_ENABLE         0
`define POS_UNIT_POINTER        8

// Reset values
`define RST_EDGE                1'h0
`define RST_NS                  30'h0000000
`define RST_SECONDS             32'h00000000
`define RST_PHASE               3'h0
`define RST_CTRL_ENABLE         1'h1
`define RST_RDATA               32'h00000000

// Phase slot codes, one per 8 ns step of the 40 ns period
`define PHASE_CODE_0NS          3'h0
`define PHASE_CODE_8NS          3'h1
`define PHASE_CODE_16NS         3'h2
`define PHASE_CODE_24NS         3'h3
`define PHASE_CODE_32NS         3'h4
`define PHASE_CODE_RSVD         3'h7

// Timing of the phase field
`define PHASE_STEP_NS           8
`define PHASE_PERIOD_NS         40
`define PHASE_SLOTS             5

`endif

// *** sample_regs_pkg.sv ***
`default_nettype none
package sample_regs_pkg;

	// Register bus address width
	typedef logic [11:0] reg_addr_t;
	// Register bus data word
	typedef logic [31:0] reg_word_t;
	// Encoded phase code
	typedef logic [2:0] phase_code_t;
	// Phase slot number 0..4 from the capture engine
	typedef logic [2:0] phase_index_t;
	// Storage entry index: {unit, sample}
	typedef logic [1:0] entry_t;

	// Which sample window a capture lands in
	typedef enum logic
	{
		SLOT_FIFTH = 1'b0,
		SLOT_SIXTH = 1'b1
	} sample_slot_e;

endpackage
`default_nettype wire

// *** event_timestamp_sample_5_6_regs.sv ***
// Notes on behaviour
// - Unit pointer bit selects shown unit values
// - Bit 30 shows capture edge, rising one
// - Bits 29:0 hold nanoseconds low word
// - Seconds register holds full 32-bit seconds
// - Phase field codes the 8ns slot
// - Third slot code chosen 010, not 101
// - Sixth sample has own identical register triple
// - Sample fields read-only, zero after reset
//
// Local design decision: the address-and-strobe port.
`include "sample_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module event_timestamp_sample_5_6_regs
	import sample_regs_pkg::*;
(
	input  wire logic        clk,             // 40 MHz system clock
	input  wire logic        rst_n,           // Synchronous reset
	input  wire logic [11:0] reg_addr,        // Byte address
	input  wire logic [31:0] reg_wdata,       // Write data
	input  wire logic        reg_wr,          // Write strobe
	input  wire logic        reg_rd,          // Read strobe
	output logic      [31:0] reg_rdata,       // Read data, cycle after
	input  wire logic [31:0] unit_index_reg,  // Global unit index word
	input  wire logic        cap_valid,       // Capture pulse
	input  wire logic        cap_unit,        // Capturing unit
	input  wire logic        cap_slot,        // 0 fifth, 1 sixth
	input  wire logic        cap_rising,      // Edge was rising
	input  wire logic [29:0] cap_ns,          // Nanoseconds word
	input  wire logic [31:0] cap_s,           // Seconds word
	input  wire logic [2:0]  cap_phase_index, // 8 ns slot number
	output logic             capture_enable   // Control bit view
);

	// Number of stored entries: two units by two samples
	// Entry index is {unit, sample}, so unit 0 fills 0..1
	// and unit 1 fills 2..3; the read side uses the same
	// packing, which keeps the two sides in step by build.
	localparam int ENTRIES = 4;

	// Edge polarity per entry
	logic        edge_q  [ENTRIES];
	// Nanoseconds per entry
	logic [29:0] ns_q    [ENTRIES];
	// Seconds per entry
	logic [31:0] sec_q   [ENTRIES];
	// Phase code per entry
	logic [2:0]  phase_q [ENTRIES];

	// Encoded phase of the incoming capture
	phase_code_t cap_phase_code;
	// Entry written by the incoming capture
	entry_t      cap_entry;
	// Entries that the read mux looks at
	entry_t      view_fifth;
	entry_t      view_sixth;
	// Unit chosen by software through the index word
	logic        unit_pointer;
	// Combinational read value
	reg_word_t   next_rdata;
	// Decoded writes
	logic        ctrl_wr;

	// Map the slot number to its phase code
	// The engine hands over a plain slot count 0..4.
	// Codes for 0, 8, 24 and 32 ns equal the count, and
	// the 16 ns slot uses 010 so that no valid code
	// falls inside the reserved 101..111 range.
	// A count above 4 can only come from a faulty engine;
	// it is stored as 111 so software can spot it,
	// at the cost of losing the raw count.
	function automatic phase_code_t encode_phase(input phase_index_t idx);
		phase_code_t code;
		code = `PHASE_CODE_RSVD;
		case (idx)
			3'h0:
			begin
				code = `PHASE_CODE_0NS;
			end
			3'h1:
			begin
				code = `PHASE_CODE_8NS;
			end
			3'h2:
			begin
				// The printed 101 collides with the reserved range
				code = `PHASE_CODE_16NS;
			end
			3'h3:
			begin
				code = `PHASE_CODE_24NS;
			end
			3'h4:
			begin
				code = `PHASE_CODE_32NS;
			end
			default:
			begin
				// Engine fault: flag with a reserved code
				code = `PHASE_CODE_RSVD;
			end
		endcase
		return code;
	endfunction

	// Capture side decode
	always_comb
	begin
		cap_phase_code = encode_phase(cap_phase_index);
		cap_entry      = {cap_unit, cap_slot};
	end

	// Unit pointer taken from its bit in the index word
	assign unit_pointer = unit_index_reg[`POS_UNIT_POINTER];

	// Entries on view for the selected unit
	always_comb
	begin
		view_fifth = {unit_pointer, SLOT_FIFTH};
		view_sixth = {unit_pointer, SLOT_SIXTH};
	end

	// Write decode: only the control word is writable
	assign ctrl_wr = reg_wr && (reg_addr == `OFS_SAMPLE_CONTROL);

	// Capture enable control bit
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			capture_enable <= `RST_CTRL_ENABLE;
		end
		else if (ctrl_wr)
		begin
			capture_enable <= reg_wdata[`POS_CTRL_ENABLE];
		end
	end

	// One storage entry per unit and sample
	genvar e;
	generate
		for (e = 0; e < ENTRIES; e++)
		begin : g_entry
			// Entry is loaded only by the engine, never by software
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					edge_q[e]  <= `RST_EDGE;
					ns_q[e]    <= `RST_NS;
					sec_q[e]   <= `RST_SECONDS;
					phase_q[e] <= `RST_PHASE;
				end
				else if (cap_valid && capture_enable &&
					(cap_entry == entry_t'(e)))
				begin
					edge_q[e]  <= cap_rising;
					ns_q[e]    <= cap_ns;
					sec_q[e]   <= cap_s;
					phase_q[e] <= cap_phase_code;
				end
			end
		end
	endgenerate

	// Read mux; unmapped addresses read zero
	// The unit pointer is taken live in the strobe cycle,
	// so a read right after a pointer change already
	// shows the newly chosen unit. Only full-word
	// addresses decode; a misaligned address reads zero.
	// Reserved bits are left at the zero default.
	always_comb
	begin
		next_rdata = `RST_RDATA;
		case (reg_addr)
			`OFS_SAMPLE5_NANOSECONDS:
			begin
				// Bit 31 stays zero
				next_rdata[`POS_EDGE] = edge_q[view_fifth];
				next_rdata[`POS_NS_HI:0] = ns_q[view_fifth];
			end
			`OFS_SAMPLE5_SECONDS:
			begin
				next_rdata = sec_q[view_fifth];
			end
			`OFS_SAMPLE5_PHASE:
			begin
				// Bits 31:3 stay zero
				next_rdata[`POS_PHASE_HI:0] = phase_q[view_fifth];
			end
			`OFS_SAMPLE6_NANOSECONDS:
			begin
				next_rdata[`POS_EDGE] = edge_q[view_sixth];
				next_rdata[`POS_NS_HI:0] = ns_q[view_sixth];
			end
			`OFS_SAMPLE6_SECONDS:
			begin
				next_rdata = sec_q[view_sixth];
			end
			`OFS_SAMPLE6_PHASE:
			begin
				next_rdata[`POS_PHASE_HI:0] = phase_q[view_sixth];
			end
			`OFS_SAMPLE_CONTROL:
			begin
				next_rdata[`POS_CTRL_ENABLE] = capture_enable;
			end
			default:
			begin
				next_rdata = `RST_RDATA;
			end
		endcase
	end

	// Read data register: valid only the cycle after the strobe
	// The bus never waits: every read is answered in one
	// cycle, whatever the address.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			reg_rdata <= `RST_RDATA;
		end
		else if (reg_rd)
		begin
			// Sampled view: a capture in the same cycle shows next time
			reg_rdata <= next_rdata;
		end
		else
		begin
			// Idle bus reads zero, so stale data cannot be mistaken
			reg_rdata <= `RST_RDATA;
		end
	end

	// Writes to sample addresses fall through with no effect
	// hold because only ctrl_wr loads anything

endmodule // event_timestamp_sample_5_6_regs

`default_nettype wire

// *** sample_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sample_regs_assertions
(
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic [11:0]	reg_addr,
	input wire logic	reg_rd,
	input wire logic [31:0]	reg_rdata,
	input wire logic [31:0]	unit_index_reg,
	input wire logic	cap_valid,
	input wire logic	cap_unit,
	input wire logic	cap_slot,
	input wire logic	cap_rising,
	input wire logic [29:0]	cap_ns,
	input wire logic [31:0]	cap_s,
	input wire logic [2:0]	cap_phase_index,
	input wire logic	capture_enable
);
	// One domain, so clock and reset are stated once
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero between reads");
	AST_NS_RSVD: assert property (reg_rd && reg_addr inside {12'h584,
		12'h590} |=> !reg_rdata[31]) else $error("ns bit 31 set");
	AST_PH_RSVD: assert property (reg_rd && reg_addr inside {12'h58c,
		12'h598} |=> reg_rdata[31:3] == 29'h0) else $error("phase high set");
	AST_PH_CODE: assert property (reg_rd && reg_addr inside {12'h58c,
		12'h598} |=> !(reg_rdata[2:0] inside {3'h5, 3'h6}))
		else $error("phase code in reserved range");
	AST_UNMAP: assert property (reg_rd && !(reg_addr inside {12'h584,
		12'h588, 12'h58c, 12'h590, 12'h594, 12'h598, 12'h5f0})
		|=> reg_rdata == 32'h0) else $error("unmapped read not zero");
	// Capture then read of the shown unit in the very next cycle
	AST_CAP_NS: assert property (cap_valid && capture_enable && !cap_slot
		##1 reg_rd && reg_addr == 12'h584 && !cap_valid
		&& unit_index_reg[8] == $past(cap_unit) |=> reg_rdata ==
		{1'b0, $past(cap_rising, 2), $past(cap_ns, 2)})
		else $error("fifth ns word wrong");
	AST_CAP_S: assert property (cap_valid && capture_enable && cap_slot
		##1 reg_rd && reg_addr == 12'h594 && !cap_valid
		&& unit_index_reg[8] == $past(cap_unit)
		|=> reg_rdata == $past(cap_s, 2)) else $error("sixth seconds wrong");
	AST_CAP_PH: assert property (cap_valid && capture_enable && !cap_slot
		##1 reg_rd && reg_addr == 12'h58c && !cap_valid
		&& unit_index_reg[8] == $past(cap_unit) |=> reg_rdata[2:0] ==
		($past(cap_phase_index, 2) > 3'h4 ? 3'h7 : $past(cap_phase_index, 2)))
		else $error("fifth phase code wrong");
endmodule // sample_regs_assertions
bind event_timestamp_sample_5_6_regs sample_regs_assertions
	sample_regs_assertions_inst (.*);
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic	clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cap_valid = 0;
	logic	cap_unit = 0, cap_slot = 0, cap_rising = 0, capture_enable;
	logic [11:0]	reg_addr = 0;
	logic [31:0]	reg_wdata = 0, unit_index_reg = 0, cap_s = 0, reg_rdata;
	logic [29:0]	cap_ns = 0;
	logic [2:0]	cap_phase_index = 0;
	logic [31:0]	m[logic [12:0]];	// Model words by {unit, address}
	int	error_cnt = 0, total_checks = 0;
	bit	en = 1;	// Model of capture enable
	logic [31:0]	exp_v = 0;	// Expected word of the pending read
	bit	pend = 0;	// A read answer is due this cycle
	always #12.5 clk = ~clk;
	event_timestamp_sample_5_6_regs event_timestamp_sample_5_6_regs_inst (.*);
	task chk(logic [31:0] g, logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Missing model entry means never captured, so zero
	task rd(logic [11:0] a);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		exp_v = m.exists({unit_index_reg[8], a}) ?
			m[{unit_index_reg[8], a}] : 32'h0;
		pend = 1;
	endtask
	// Read answer looked at mid-cycle, while it stands
	always @(negedge clk)
	begin
		if (pend)
		begin
			pend = 0;
			chk(reg_rdata, exp_v);
		end
	end
	task wr(logic [11:0] a, logic [31:0] d);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
		if (a == 12'h5f0)
			en = d[0];
	endtask
	task cap(bit u, bit sl, logic [2:0] p);
		logic [29:0] n;
		logic [31:0] t;
		logic [12:0] b;
		n = $urandom;
		t = $urandom;
		b = {u, sl ? 12'h590 : 12'h584};
		{cap_valid, cap_unit, cap_slot, cap_rising} <= {1'b1, u, sl, t[0]};
		{cap_ns, cap_s, cap_phase_index} <= {n, t, p};
		@(posedge clk);
		cap_valid <= 0;
		if (en)
		begin
			m[b] = {1'b0, t[0], n};
			m[b + 4] = t;
			m[b + 8] = p > 4 ? 32'h7 : {29'h0, p};
		end
	endtask
	task stop_test;
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h6de2c7c4));
		repeat (20) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		chk(capture_enable, 32'h1);
		for (int i = 0; i < 7; i++)
			rd(12'h584 + 12'(4 * i));
		// Unit picked at random, read of captured slot next cycle
		for (int i = 0; i < 96; i++)
		begin
			cap($urandom, i % 2, 3'((i / 6) % 8));
			unit_index_reg <= $urandom;
			rd((i % 2 ? 12'h590 : 12'h584) + 12'(4 * ((i / 2) % 3)));
			rd(12'($urandom_range(12'h598, 12'h580)) & 12'hffc);
			wr(12'h584 + 12'(4 * ($urandom % 6)), $urandom);
		end
		wr(12'h5f0, 0);
		@(posedge clk);
		chk(capture_enable, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			cap(i / 2, i % 2, 3'h1);
			rd(12'h584 + 12'(12 * (i % 2)));
		end
		wr(12'h5f0, 1);
		stop_test;
	end
	// Whole run is well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
